// *** hw/adc_convert_control.sv ***
// Purpose: start edge handling, conversion timing, sleep and serial readout
// Assumes: start, serial clock and range strap arrive from outside core_clk
// Notes:   the sar array hands its raw offset-binary code on convResult
`timescale 1ns/1ps

// ==========================================================
// top module
module adc_convert_control
    import adc_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic    core_clk,
    input  wire logic    reset,
    // host pins
    input  wire logic    conversionStart_n,
    input  wire logic    serialClk,
    output logic         busy,
    output logic         resultOutLine,
    output logic         resultOutLineEn,
    // analog side
    input  wire result_t convResult,
    input  wire logic    rangeBipolar,
    output logic         trackHold,
    output logic         poweredDown,
    output logic         resultValid
);

    // ==========================================================
    // state of the whole control
    typedef struct packed {
        logic                startMeta;
        logic                startSync;
        logic                startPrev;
        logic                clkMeta;
        logic                clkSync;
        logic                clkPrev;
        logic                rangeMeta;
        logic                rangeSync;
        phase_t              phase;
        logic [TIMER_W-1:0]  timer;
        logic                pending;
        result_t             result;
        logic                haveResult;
        logic                busyOut;
        logic                holdOut;
        logic                sleepOut;
        logic                bitOut;
        logic                enOut;
    } ctrl_state_t;

    ctrl_state_t c_q;
    ctrl_state_t c_d;

    readout_if link ();

    // ==========================================================
    // coding of the raw code for the selected range
    // the array works in offset binary; bipolar parts flip the msb
    function automatic result_t encode_result(input result_t raw, input logic bipolar);
        result_t coded;
        coded = raw;
        if (bipolar) begin
            coded[RESULT_BITS-1] = ~raw[RESULT_BITS-1];
        end
        return coded;
    endfunction

    // ==========================================================
    // edge decode from the synchronised level and its previous copy
    function automatic logic fell(input logic now, input logic prev);
        return prev && !now;
    endfunction

    function automatic logic rose(input logic now, input logic prev);
        return !prev && now;
    endfunction

    // ==========================================================
    // combinational edges, read from the second flop onward only
    logic startFell;
    logic startRose;
    logic clkFell;
    logic timerDone;
    logic readoutClear;

    always_comb begin
        startFell = fell(c_q.startSync, c_q.startPrev);
        startRose = rose(c_q.startSync, c_q.startPrev);
        clkFell   = fell(c_q.clkSync, c_q.clkPrev);
    end

    // timer end depends on which phase is being timed
    always_comb begin
        timerDone = 1'b0;
        if (c_q.phase == PH_CONVERT) begin
            timerDone = (c_q.timer == CONV_LAST);
        end else if (c_q.phase == PH_WAKE) begin
            timerDone = (c_q.timer == WAKE_LAST);
        end
    end

    // ==========================================================
    // next state
    always_comb begin
        c_d = c_q;

        // two-flop synchronisers for every pin input
        c_d.startMeta = conversionStart_n;
        c_d.startSync = c_q.startMeta;
        c_d.startPrev = c_q.startSync;
        c_d.clkMeta   = serialClk;
        c_d.clkSync   = c_q.clkMeta;
        c_d.clkPrev   = c_q.clkSync;
        c_d.rangeMeta = rangeBipolar;
        c_d.rangeSync = c_q.rangeMeta;

        // phase timer, runs in convert and wake only, cleared on every phase change
        c_d.timer = c_q.timer + TIMER_W'(1);

        unique case (c_q.phase)
            PH_READY: begin
                c_d.timer = TIMER_RST;
                if (startFell) begin
                    c_d.phase   = PH_CONVERT;
                    c_d.holdOut = 1'b1;
                    c_d.busyOut = 1'b1;
                end
            end
            PH_CONVERT: begin
                if (timerDone) begin
                    // result latched here so a frame always sees a whole word
                    c_d.result     = encode_result(convResult, c_q.rangeSync);
                    c_d.haveResult = 1'b1;
                    c_d.busyOut    = 1'b0;
                    c_d.holdOut    = 1'b0;
                    c_d.timer      = TIMER_RST;
                    if (!c_q.startSync) begin
                        c_d.phase    = PH_SLEEP;
                        c_d.sleepOut = 1'b1;
                    end else begin
                        c_d.phase = PH_READY;
                    end
                end
            end
            PH_SLEEP: begin
                c_d.timer = TIMER_RST;
                if (startRose) begin
                    c_d.phase = PH_WAKE;
                end else if (startFell) begin
                    // a start seen while asleep waits for its rising edge
                    c_d.phase   = PH_ARMED;
                    c_d.holdOut = 1'b1;
                    c_d.busyOut = 1'b1;
                    c_d.pending = 1'b1;
                end
            end
            PH_ARMED: begin
                c_d.timer = TIMER_RST;
                if (startRose) begin
                    c_d.phase = PH_WAKE;
                end
            end
            PH_WAKE: begin
                if (startFell) begin
                    c_d.pending = 1'b1;
                    c_d.holdOut = 1'b1;
                    c_d.busyOut = 1'b1;
                end
                if (timerDone) begin
                    c_d.sleepOut = 1'b0;
                    c_d.timer    = TIMER_RST;
                    if (c_q.pending || startFell) begin
                        // wake-up plus conversion gives the 10 us figure
                        c_d.phase   = PH_CONVERT;
                        c_d.pending = 1'b0;
                    end else begin
                        c_d.phase = PH_READY;
                    end
                end
            end
            default: begin
                // illegal one-hot code: recover to ready, nothing held
                c_d.phase    = PH_READY;
                c_d.timer    = TIMER_RST;
                c_d.pending  = 1'b0;
                c_d.busyOut  = 1'b0;
                c_d.holdOut  = 1'b0;
                c_d.sleepOut = 1'b0;
            end
        endcase

        // line follows the shifter one cycle later so pins come from flops
        c_d.bitOut = link.dataBit;
        c_d.enOut  = link.dataEn;
    end

    // ==========================================================
    // shifter hookup
    // frame built from the latched result, two leading zeros first
    assign link.fallStrobe = clkFell;
    assign link.frameWord  = {LEAD_VALUE, c_q.result};

    // a new start abandons a cut frame, so the line floats and realigns
    assign readoutClear = reset || startFell;

    serial_shifter u_shifter (
        .core_clk (core_clk),
        .reset    (readoutClear),
        .link     (link.shifter)
    );

    // ==========================================================
    // registers
    // synchroniser flops reset to a released start and a low clock,
    // so leaving reset never fakes an edge
    always_ff @(posedge core_clk) begin
        if (reset) begin
            c_q <= '{startMeta: 1'b1, startSync: 1'b1, startPrev: 1'b1,
                     clkMeta: 1'b0, clkSync: 1'b0, clkPrev: 1'b0,
                     rangeMeta: 1'b0, rangeSync: 1'b0,
                     phase: PH_READY, timer: TIMER_RST, pending: 1'b0,
                     result: RESULT_RST, haveResult: 1'b0,
                     busyOut: 1'b0, holdOut: 1'b0, sleepOut: 1'b0,
                     bitOut: 1'b0, enOut: 1'b0};
        end else begin
            c_q <= c_d;
        end
    end

    // ==========================================================
    // outputs, all straight from flops
    assign busy            = c_q.busyOut;
    assign trackHold       = c_q.holdOut;
    assign poweredDown     = c_q.sleepOut;
    assign resultValid     = c_q.haveResult;
    assign resultOutLine   = c_q.bitOut;
    assign resultOutLineEn = c_q.enOut;

endmodule

// *** hw/adc_ctrl_pkg.sv ***
// Purpose: shared constants and types for the converter control and readout
// Assumes: core clock of 200 MHz, one clock domain
// Notes:   times are kept in ns, cycle counts are derived from them
package adc_ctrl_pkg;

    // ==========================================================
    // clock and timing
    localparam int unsigned CLK_PERIOD_NS = 5;
    // conversion time in the high sampling mode
    localparam int unsigned CONV_TIME_NS  = 5000;
    // wake-up part of the 10 us auto-sleep conversion
    localparam int unsigned WAKE_TIME_NS  = 5000;
    // guaranteed data hold after a falling serial clock edge
    localparam int unsigned HOLD_TIME_NS  = 10;

    // longest times round down, least times round up
    localparam int unsigned CONV_CYC = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned WAKE_CYC = WAKE_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned HOLD_CYC = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int unsigned TIMER_W = 10;
    localparam logic [TIMER_W-1:0] CONV_LAST = TIMER_W'(CONV_CYC - 1);
    localparam logic [TIMER_W-1:0] WAKE_LAST = TIMER_W'(WAKE_CYC - 1);
    localparam logic [TIMER_W-1:0] TIMER_RST = 10'h000;

    // ==========================================================
    // frame layout
    localparam int unsigned RESULT_BITS = 14;
    localparam int unsigned LEAD_ZEROS  = 2;
    localparam int unsigned FRAME_BITS  = 16;
    localparam int unsigned COUNT_W     = 5;
    localparam logic [COUNT_W-1:0] COUNT_RST  = 5'h00;
    localparam logic [COUNT_W-1:0] COUNT_LAST = COUNT_W'(FRAME_BITS);
    localparam int unsigned HOLD_W = 2;
    localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CYC - 1);
    localparam logic [HOLD_W-1:0] HOLD_RST  = 2'h0;
    localparam logic [LEAD_ZEROS-1:0]  LEAD_VALUE = 2'h0;
    localparam logic [RESULT_BITS-1:0] RESULT_RST = 14'h0000;
    localparam logic [FRAME_BITS-1:0]  FRAME_RST  = 16'h0000;

    // ==========================================================
    // converter phases
    typedef enum logic [4:0] {
        PH_READY   = 5'b0_0001,
        PH_CONVERT = 5'b0_0010,
        PH_SLEEP   = 5'b0_0100,
        PH_ARMED   = 5'b0_1000,
        PH_WAKE    = 5'b1_0000
    } phase_t;

    typedef logic [RESULT_BITS-1:0] result_t;
    typedef logic [FRAME_BITS-1:0]  frame_t;

endpackage

// *** hw/readout_if.sv ***
// Purpose: carrier between converter control and the serial shifter
// Assumes: both ends on core_clk
// Notes:   fall strobe is one cycle wide
`timescale 1ns/1ps
interface readout_if;
    import adc_ctrl_pkg::*;
    logic   fallStrobe;   // falling serial clock edge seen
    frame_t frameWord;    // frame to be sent
    logic   dataBit;      // bit on the line
    logic   dataEn;       // line driven

    modport control (output fallStrobe, output frameWord, input dataBit, input dataEn);
    modport shifter (input fallStrobe, input frameWord, output dataBit, output dataEn);
endinterface

// *** hw/serial_shifter.sv ***
// Purpose: sixteen-bit serial frame out, one bit per falling edge
// Assumes: fall strobe already synchronised and edge detected
// Notes:   line is released a hold time after the last edge
`timescale 1ns/1ps
module serial_shifter
    import adc_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    // link side
    readout_if.shifter link
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [COUNT_W-1:0] count;
        frame_t             shift;
        logic               bitOut;
        logic               enOut;
        logic               holding;
        logic [HOLD_W-1:0]  holdCnt;
    } shift_state_t;

    shift_state_t s_q;
    shift_state_t s_d;

    // ==========================================================
    // next state
    always_comb begin
        s_d = s_q;
        if (link.fallStrobe && !s_q.holding) begin
            if (s_q.count == COUNT_RST) begin
                // frame captured at its first edge, msb first
                s_d.shift  = link.frameWord << 1;
                s_d.bitOut = link.frameWord[FRAME_BITS-1];
                s_d.enOut  = 1'b1;
            end else begin
                s_d.shift  = s_q.shift << 1;
                s_d.bitOut = s_q.shift[FRAME_BITS-1];
            end
            s_d.count = s_q.count + COUNT_W'(1);
            if (s_q.count == COUNT_LAST - COUNT_W'(1)) begin
                s_d.holding = 1'b1;
                s_d.holdCnt = HOLD_RST;
            end
        end else if (s_q.holding) begin
            // last bit stays for the hold time, then the line floats
            if (s_q.holdCnt == HOLD_LAST) begin
                s_d.holding = 1'b0;
                s_d.enOut   = 1'b0;
                s_d.count   = COUNT_RST;
            end else begin
                s_d.holdCnt = s_q.holdCnt + HOLD_W'(1);
            end
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_q <= '{count: COUNT_RST, shift: FRAME_RST, bitOut: 1'b0,
                     enOut: 1'b0, holding: 1'b0, holdCnt: HOLD_RST};
        end else begin
            s_q <= s_d;
        end
    end

    assign link.dataBit = s_q.bitOut;
    assign link.dataEn  = s_q.enOut;

endmodule

// *** tb/adc_convert_and_serial_readout_test.sv ***
// Purpose: self-checking bench for the converter control
// Assumes: host model drives start and serial clock
// Notes:   table rows cover codes in both range codings
`timescale 1ns/1ps
module adc_convert_and_serial_readout_test;
    import adc_ctrl_pkg::*;

    typedef struct {
        result_t code;
        logic    bip;
        frame_t  frame;
    } row_t;

    // ==========================================================
    // signals
    logic    core_clk     = 1'b0;
    logic    reset        = 1'b1;
    result_t convResult   = RESULT_RST;
    logic    rangeBipolar = 1'b0;
    logic    startN, sclk, busy, dataLine, dataEn, trackHold, poweredDown, resultValid;
    int      fails        = 0;
    int      cmp_count    = 0;
    int      cycles       = 0;
    row_t    rows [7]     = '{
        '{14'h0000, 1'b0, 16'h0000}, '{14'h3fff, 1'b0, 16'h3fff},
        '{14'h2aaa, 1'b0, 16'h2aaa}, '{14'h2000, 1'b1, 16'h0000},
        '{14'h1fff, 1'b1, 16'h3fff}, '{14'h1555, 1'b1, 16'h3555},
        '{14'h0001, 1'b1, 16'h2001}};

    always #2.5 core_clk = ~core_clk;

    adc_convert_control i_adc_convert_control (
        .core_clk(core_clk), .reset(reset), .conversionStart_n(startN), .serialClk(sclk),
        .busy(busy), .resultOutLine(dataLine), .resultOutLineEn(dataEn),
        .convResult(convResult), .rangeBipolar(rangeBipolar), .trackHold(trackHold),
        .poweredDown(poweredDown), .resultValid(resultValid));
    host_model i_host_model (
        .core_clk(core_clk), .startN(startN), .sclk(sclk), .dataLine(dataLine),
        .dataEn(dataEn));

    // ==========================================================
    // checking and reporting
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_word(input frame_t got, input frame_t exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        if (fails == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // busy run length in core cycles, waits are bounded against hangs
    task automatic busy_run(output int len);
        len = 0;
        for (int i = 0; i < 3000 && busy !== 1'b1; i++) @(posedge core_clk);
        while (busy === 1'b1 && len < 3000) begin
            @(posedge core_clk);
            len++;
        end
        #1;
    endtask

    // hang guard, well above the expected length of the run
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 30000) begin
            fails++;
            complete_run();
        end
    end

    // ==========================================================
    // sequence
    initial begin
        int     len;
        int     off;
        frame_t word;
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        #1;
        cmp_word({11'h000, busy, dataEn, trackHold, poweredDown, resultValid}, 16'h0000);
        // table rows: convert, then read the frame once busy is low
        foreach (rows[i]) begin
            @(posedge core_clk);
            convResult   <= rows[i].code;
            rangeBipolar <= rows[i].bip;
            fork
                i_host_model.start_pulse(20);
                busy_run(len);
            join
            cmp_word(16'(len), 16'(CONV_CYC));
            cmp_bit(poweredDown, 1'b0);
            cmp_bit(resultValid, 1'b1);
            cmp_bit(dataEn, 1'b0);
            i_host_model.read_frame(word, off);
            cmp_word(word, rows[i].frame);
            cmp_word(16'(off), 16'h0000);
            repeat (60) @(posedge core_clk);
            #1;
            cmp_bit(dataEn, 1'b0);
        end
        // start held low past the end: sleep, no second start, then wake
        fork
            i_host_model.start_pulse(1500);
            begin
                busy_run(len);
                repeat (2) @(posedge core_clk);
                #1;
                cmp_bit(poweredDown, 1'b1);
                off = 0;
                repeat (300) begin
                    @(posedge core_clk);
                    if (busy !== 1'b0) off++;
                end
                cmp_word(16'(off), 16'h0000);
            end
        join
        len = 0;
        while (poweredDown === 1'b1 && len < 3000) begin
            @(posedge core_clk);
            len++;
        end
        cmp_bit(logic'(len >= WAKE_CYC && len <= WAKE_CYC + 8), 1'b1);
        // short start during wake-up is kept and converted once awake
        convResult   <= 14'h1234;
        rangeBipolar <= 1'b0;
        i_host_model.start_pulse(1500);
        repeat (200) @(posedge core_clk);
        i_host_model.start_pulse(20);
        #1;
        cmp_bit(busy, 1'b1);
        cmp_bit(trackHold, 1'b1);
        len = 0;
        while (poweredDown === 1'b1 && len < 3000) begin
            @(posedge core_clk);
            len++;
        end
        busy_run(len);
        cmp_word(16'(len), 16'(CONV_CYC));
        i_host_model.read_frame(word, off);
        cmp_word(word, 16'h1234);
        repeat (60) @(posedge core_clk);
        // reset in the middle of a conversion clears every output
        i_host_model.start_pulse(20);
        repeat (100) @(posedge core_clk);
        reset <= 1'b1;
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        #1;
        cmp_word({11'h000, busy, dataEn, trackHold, poweredDown, resultValid}, 16'h0000);
        complete_run();
    end
endmodule

bind adc_convert_control adc_convert_control_properties i_adc_convert_control_properties (
    .core_clk(core_clk), .reset(reset), .conversionStart_n(conversionStart_n),
    .serialClk(serialClk), .busy(busy), .resultOutLine(resultOutLine),
    .resultOutLineEn(resultOutLineEn), .trackHold(trackHold), .poweredDown(poweredDown));

// *** tb/adc_convert_control_properties.sv ***
// Purpose: port properties of the converter control
// Assumes: single core_clk domain, synchronous reset
// Notes:   pin events lag three to five cycles through the synchronisers
`timescale 1ns/1ps
module adc_convert_control_properties
    import adc_ctrl_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // host pins
    input wire logic conversionStart_n,
    input wire logic serialClk,
    input wire logic busy,
    input wire logic resultOutLine,
    input wire logic resultOutLineEn,
    // analog side
    input wire logic trackHold,
    input wire logic poweredDown
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    // ==========================================================
    // helpers
    // busy run length; a run through sleep is longer, so it is flagged
    logic [10:0] runLen_q;
    logic        slept_q;
    logic [10:0] wakeLen_q;
    always_ff @(posedge core_clk) begin
        runLen_q <= busy ? runLen_q + 11'h001 : 11'h000;
        slept_q  <= busy & (slept_q | poweredDown);
    end

    // wake-up length from the rising start edge; too long for a delay range
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wakeLen_q <= 11'h000;
        end else if (!poweredDown) begin
            wakeLen_q <= 11'h000;
        end else if (wakeLen_q != 11'h000 || $rose(conversionStart_n)) begin
            wakeLen_q <= wakeLen_q + 11'h001;
        end
    end

    // ==========================================================
    // conversion control
    property p_busy_rise;
        $fell(conversionStart_n) && !busy && !poweredDown |-> ##[3:4] $rose(busy);
    endproperty
    a_busy_rise: assert property (p_busy_rise)
        else $error("busy did not follow the start edge");
    property p_conv_time;
        $fell(busy) && !slept_q |-> runLen_q == 11'(CONV_CYC);
    endproperty
    a_conv_time: assert property (p_conv_time)
        else $error("conversion length wrong");
    property p_edge_only;
        !busy && !conversionStart_n && !$past(conversionStart_n)
            && !$past(conversionStart_n, 5) |=> !busy;
    endproperty
    a_edge_only: assert property (p_edge_only)
        else $error("steady low level started a conversion");
    property p_sleep_enter;
        $fell(busy) && !conversionStart_n && !$past(conversionStart_n, 4)
            |-> ##[0:1] poweredDown;
    endproperty
    a_sleep_enter: assert property (p_sleep_enter)
        else $error("no power-down with start low");
    property p_stay_awake;
        $fell(busy) && conversionStart_n && $past(conversionStart_n, 4) |-> !poweredDown[*2];
    endproperty
    a_stay_awake: assert property (p_stay_awake)
        else $error("power-down with start high");
    property p_wake;
        $fell(poweredDown) |-> wakeLen_q == 11'(WAKE_CYC + 3);
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake-up time wrong");
    property p_wake_bound;
        poweredDown |-> wakeLen_q <= 11'(WAKE_CYC + 3);
    endproperty
    a_wake_bound: assert property (p_wake_bound)
        else $error("wake-up runs too long");
    property p_track_hold;
        $changed(busy) && !poweredDown |-> trackHold == busy;
    endproperty
    a_track_hold: assert property (p_track_hold)
        else $error("track/hold not moving with busy");

    // ==========================================================
    // serial readout
    property p_hold_time;
        $fell(serialClk) && resultOutLineEn |=> $stable(resultOutLine)[*2];
    endproperty
    a_hold_time: assert property (p_hold_time)
        else $error("data changed inside the hold time");
    property p_drive_start;
        $rose(resultOutLineEn) |-> !$past(serialClk, 3)
            && ($past(serialClk, 4) || $past(serialClk, 5));
    endproperty
    a_drive_start: assert property (p_drive_start)
        else $error("data line driven without a falling clock edge");
endmodule

// *** tb/host_model.sv ***
// Purpose: host that starts conversions and clocks frames out
// Assumes: core_clk paces every pin change
// Notes:   serial clock runs only inside frames, 32 core cycles a bit
`timescale 1ns/1ps
module host_model
    import adc_ctrl_pkg::*;
(
    // clock
    input  wire logic core_clk,
    // device pins
    output logic      startN,
    output logic      sclk,
    input  wire logic dataLine,
    input  wire logic dataEn
);
    // idle levels from time zero
    initial begin
        startN = 1'b1;
        sclk   = 1'b0;
    end

    // start pulse, low for a number of core cycles
    task automatic start_pulse(input int lowCyc);
        @(posedge core_clk) startN <= 1'b0;
        repeat (lowCyc) @(posedge core_clk);
        startN <= 1'b1;
    endtask

    // one frame, msb first; sampled early in the low phase so bit 16 is
    // caught before the line floats; clock parked low afterwards
    task automatic read_frame(output frame_t word, output int offCnt);
        word   = FRAME_RST;
        offCnt = 0;
        for (int i = 0; i < FRAME_BITS; i++) begin
            @(posedge core_clk) sclk <= 1'b1;
            repeat (16) @(posedge core_clk);
            sclk <= 1'b0;
            repeat (5) @(posedge core_clk);
            #1;
            word = {word[FRAME_BITS-2:0], dataLine};
            if (dataEn !== 1'b1) offCnt++;
            repeat (10) @(posedge core_clk);
        end
    endtask
endmodule
